// >>> core/ppc_pkg.sv
// Package for the pack protection controller: register map, field layout,
// reset values, timing constants and the carrier structs.
// Assumes a 50 MHz system clock and word-aligned AHB-Lite register access.
package ppc_pkg;

   // Clock rate in kHz, kept small so the cycle products stay in 32 bits
   localparam int CLK_KHZ = 50_000;

   // Times as printed, each in its own unit
   localparam int SCAN_PERIOD_MS = 640;
   localparam int SCAN_ON_MS = 5;
   localparam int SETTLE_MS = 1;
   localparam int OC_UNIT_US = 1000;
   localparam int SC_UNIT_US = 100;

   // Derived cycle counts (least times round up, none below one cycle)
   localparam int SCAN_PERIOD_CYC = SCAN_PERIOD_MS * CLK_KHZ;
   localparam int SCAN_ON_CYC = SCAN_ON_MS * CLK_KHZ;
   localparam int SETTLE_CYC = SETTLE_MS * CLK_KHZ;
   localparam int OC_UNIT_CYC = (OC_UNIT_US * CLK_KHZ + 999) / 1000;
   localparam int SC_UNIT_CYC = (SC_UNIT_US * CLK_KHZ + 999) / 1000;

   // Register indices; byte address is four times the index
   localparam logic [2:0] STATUS_IDX = 3'h0;
   localparam logic [2:0] CONTROL_IDX = 3'h1;
   localparam logic [2:0] BALANCE_IDX = 3'h2;
   localparam logic [2:0] OVERRIDE_IDX = 3'h3;
   localparam logic [2:0] AOSEL_IDX = 3'h4;
   localparam logic [2:0] DISCHARGE_CFG_IDX = 3'h5;
   localparam logic [2:0] CHARGE_CFG_IDX = 3'h6;

   // Discharge threshold config fields
   localparam int DOC_THR_POS = 0;
   localparam int SC_THR_POS = 2;
   localparam int DOC_DLY_POS = 4;
   localparam int SC_DLY_POS = 7;
   // Charge / time scale config fields
   localparam int COC_THR_POS = 0;
   localparam int COC_DLY_POS = 2;
   // Control fields
   localparam int CHG_CTRL_POS = 0;
   localparam int DIS_CTRL_POS = 1;
   localparam int LDMON_POS = 2;

   // Reset values
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [5:0] BAL_RST = 6'h00;
   localparam logic [3:0] AOSEL_RST = 4'h0;
   // Analog select code that routes the thermistor input
   localparam logic [3:0] AO_EXT_TEMP = 4'h9;

   // Digital comparator results from the analog front end
   typedef struct packed {
      logic discharge_oc;
      logic charge_oc;
      logic short_circuit;
      logic internal_hot;
      logic thermistor_low;
      logic load_high;
   } ppc_sense_s;

   // Sticky fault flags, status register bits [4:0]
   typedef struct packed {
      logic external_overtemp_flag;
      logic internal_overtemp_flag;
      logic short_circuit_flag;
      logic charge_overcurrent_flag;
      logic discharge_overcurrent_flag;
   } ppc_flags_s;

   // Override and scan configuration, register bits [6:0]
   typedef struct packed {
      logic thermistor_supply_force;
      logic auto_scan_disable;
      logic external_overtemp_override;
      logic internal_overtemp_override;
      logic charge_oc_override;
      logic short_circuit_override;
      logic discharge_oc_override;
   } ppc_ovr_s;

endpackage

// >>> core/ppc_sync.sv
// Two-flop synchroniser for a group of asynchronous comparator levels.
// Assumes inputs are quasi-static levels; no bus coherency is implied.
`timescale 1ns/100ps
module ppc_sync #(
   parameter int WIDTH = 6
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta;

   // First stage is read only by the second
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule

// >>> core/ppc_delay_filter.sv
// Persistence filter: one-cycle event once a condition has held for limit_i
// cycles. Assumes limit_i is at least one and stable while counting.
`timescale 1ns/100ps
module ppc_delay_filter #(
   parameter int CW = 26
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic cond_i,
   input wire logic [CW-1:0] limit_i,
   output logic event_o
);
   logic [CW-1:0] cnt;

   // Count while held, saturate at the limit so only one event fires
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || !cond_i) begin
         cnt <= '0;
      end else if (cnt < limit_i) begin
         cnt <= cnt + 1'b1;
      end
   end

   // Event in the cycle the count reaches the limit
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         event_o <= 1'b0;
      end else begin
         event_o <= cond_i && (cnt == limit_i - 1'b1);
      end
   end
endmodule

// >>> core/ppc_top.sv
// Pack protection controller: overcurrent and over-temperature protection,
// load monitor and thermistor scan, with an AHB-Lite register slave.
// Assumes comparator levels arrive asynchronously and thresholds are analog.
`timescale 1ns/100ps
module ppc_top #(
   parameter int OC_UNIT_CYC = ppc_pkg::OC_UNIT_CYC,
   parameter int SC_UNIT_CYC = ppc_pkg::SC_UNIT_CYC,
   parameter int SCAN_PERIOD_CYC = ppc_pkg::SCAN_PERIOD_CYC,
   parameter int SCAN_ON_CYC = ppc_pkg::SCAN_ON_CYC,
   parameter int SETTLE_CYC = ppc_pkg::SETTLE_CYC
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire ppc_pkg::ppc_sense_s sense_i,
   output logic charge_switch_drive_o,
   output logic discharge_switch_drive_o,
   output logic [5:0] balance_o,
   output logic load_monitor_pulldown_o,
   output logic thermistor_supply_out_o,
   output logic [3:0] analog_out_select_o,
   output logic [7:0] discharge_cfg_o,
   output logic [7:0] charge_cfg_o
);
   import ppc_pkg::*;

   localparam int CW = 26;

   ppc_sense_s sense;
   logic [7:0] discharge_threshold_config;
   logic [7:0] charge_timescale_config;
   ppc_flags_s flags;
   ppc_ovr_s ovr;
   logic charge_switch_ctrl;
   logic discharge_switch_ctrl;
   logic load_monitor_enable;
   logic load_present_status;
   logic [5:0] balance;
   logic [3:0] analog_out_select;
   logic dp_wr;
   logic dp_ok;
   logic [2:0] dp_idx;
   logic addr_take;
   logic addr_ok;
   logic wr_en;
   logic [31:0] rd_word;
   logic doc_evt;
   logic coc_evt;
   logic sc_evt;
   logic trip;
   logic ot_hold;
   logic ext_hot;
   logic meas_on;
   logic scan_win;
   logic settled;
   logic [CW-1:0] scan_cnt;
   logic [CW-1:0] settle_cnt;
   logic [CW-1:0] doc_lim;
   logic [CW-1:0] coc_lim;
   logic [CW-1:0] sc_lim;
   ppc_flags_s flag_set;
   ppc_flags_s flag_clr;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisation

   // Comparator levels come from the analog domain
   ppc_sync #(.WIDTH(6)) u_sync (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .d_i(sense_i),
      .q_o(sense)
   );

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states

   assign addr_take = hsel_i && htrans_i[1] && hready_i;
   assign addr_ok = (haddr_i[31:5] == 27'h000_0000) && (haddr_i[4:2] != 3'h7);
   assign wr_en = dp_wr && dp_ok;

   // Capture the address phase for the data phase write
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         dp_wr <= 1'b0;
         dp_ok <= 1'b0;
         dp_idx <= 3'h0;
      end else if (hready_i) begin
         dp_wr <= addr_take && hwrite_i;
         dp_ok <= addr_ok;
         dp_idx <= haddr_i[4:2];
      end
   end

   // Read word selected from the address phase index
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (haddr_i[4:2])
         STATUS_IDX: rd_word = {26'h000_0000, load_present_status, flags};
         CONTROL_IDX: rd_word = {29'h0000_0000, load_monitor_enable,
                                 discharge_switch_ctrl, charge_switch_ctrl};
         BALANCE_IDX: rd_word = {26'h000_0000, balance};
         OVERRIDE_IDX: rd_word = {25'h000_0000, ovr};
         AOSEL_IDX: rd_word = {28'h000_0000, analog_out_select};
         DISCHARGE_CFG_IDX: rd_word = {24'h00_0000, discharge_threshold_config};
         CHARGE_CFG_IDX: rd_word = {24'h00_0000, charge_timescale_config};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Registered read data; unmapped reads return zero, always OKAY
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         hrdata_o <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         if (addr_take && !hwrite_i && addr_ok) begin
            hrdata_o <= rd_word;
         end else if (addr_take) begin
            hrdata_o <= 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         discharge_threshold_config <= CFG_RST;
         charge_timescale_config <= CFG_RST;
         ovr <= '0;
         analog_out_select <= AOSEL_RST;
      end else if (wr_en) begin
         if (dp_idx == DISCHARGE_CFG_IDX) begin
            discharge_threshold_config <= hwdata_i[7:0];
         end
         if (dp_idx == CHARGE_CFG_IDX) begin
            charge_timescale_config <= hwdata_i[7:0];
         end
         if (dp_idx == OVERRIDE_IDX) begin
            ovr <= ppc_ovr_s'(hwdata_i[6:0]);
         end
         if (dp_idx == AOSEL_IDX) begin
            analog_out_select <= hwdata_i[3:0];
         end
      end
   end

   // Threshold selections leave for the analog comparators
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         discharge_cfg_o <= CFG_RST;
         charge_cfg_o <= CFG_RST;
         analog_out_select_o <= AOSEL_RST;
      end else begin
         discharge_cfg_o <= discharge_threshold_config;
         charge_cfg_o <= charge_timescale_config;
         analog_out_select_o <= analog_out_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Overcurrent delay qualification

   // Delay code n selects (n + 1) time units
   assign doc_lim = CW'(({23'h00_0000, discharge_threshold_config[DOC_DLY_POS +: 3]}
                         + 26'h1) * CW'(OC_UNIT_CYC));
   assign coc_lim = CW'(({23'h00_0000, charge_timescale_config[COC_DLY_POS +: 3]}
                         + 26'h1) * CW'(OC_UNIT_CYC));
   assign sc_lim = CW'(({25'h000_0000, discharge_threshold_config[SC_DLY_POS]}
                        + 26'h1) * CW'(SC_UNIT_CYC));

   // Condition must persist through the selected delay
   ppc_delay_filter #(.CW(CW)) u_doc (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .cond_i(sense.discharge_oc),
      .limit_i(doc_lim),
      .event_o(doc_evt)
   );
   ppc_delay_filter #(.CW(CW)) u_coc (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .cond_i(sense.charge_oc),
      .limit_i(coc_lim),
      .event_o(coc_evt)
   );
   ppc_delay_filter #(.CW(CW)) u_sc (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .cond_i(sense.short_circuit),
      .limit_i(sc_lim),
      .event_o(sc_evt)
   );

   assign trip = (doc_evt && !ovr.discharge_oc_override)
               || (sc_evt && !ovr.short_circuit_override)
               || (coc_evt && !ovr.charge_oc_override);

   // Over-temperature shutdown per source unless overridden
   assign ot_hold = (sense.internal_hot && !ovr.internal_overtemp_override)
                  || (ext_hot && !ovr.external_overtemp_override);

   ////////////////////////////////////////////////////////////////////////
   // Fault flags, write one to clear

   always_comb begin
      flag_set.discharge_overcurrent_flag = doc_evt;
      flag_set.charge_overcurrent_flag = coc_evt;
      flag_set.short_circuit_flag = sc_evt;
      flag_set.internal_overtemp_flag = sense.internal_hot;
      flag_set.external_overtemp_flag = settled && sense.thermistor_low;
      flag_clr = '0;
      if (wr_en && dp_idx == STATUS_IDX) begin
         flag_clr = ppc_flags_s'(hwdata_i[4:0]);
      end
   end

   // Sticky; a set in the clearing cycle wins
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         flags <= '0;
      end else begin
         flags <= flag_set | (flags & ~flag_clr);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Switch control and balancing

   // A trip clears both control bits; writes ignored when hot
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         charge_switch_ctrl <= 1'b0;
         discharge_switch_ctrl <= 1'b0;
      end else if (trip || ot_hold) begin
         charge_switch_ctrl <= 1'b0;
         discharge_switch_ctrl <= 1'b0;
      end else if (wr_en && dp_idx == CONTROL_IDX) begin
         charge_switch_ctrl <= hwdata_i[CHG_CTRL_POS];
         discharge_switch_ctrl <= hwdata_i[DIS_CTRL_POS];
      end
   end

   // Balancing off and locked during over-temperature shutdown
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || ot_hold) begin
         balance <= BAL_RST;
      end else if (wr_en && dp_idx == BALANCE_IDX) begin
         balance <= hwdata_i[5:0];
      end
   end

   // Drives follow the control bits one cycle later
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         charge_switch_drive_o <= 1'b0;
         discharge_switch_drive_o <= 1'b0;
         balance_o <= BAL_RST;
      end else begin
         charge_switch_drive_o <= charge_switch_ctrl && !trip && !ot_hold;
         discharge_switch_drive_o <= discharge_switch_ctrl && !trip && !ot_hold;
         balance_o <= ot_hold ? BAL_RST : balance;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Load monitor

   // Enable defaults off; host sets it through the control word
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         load_monitor_enable <= 1'b0;
      end else if (wr_en && dp_idx == CONTROL_IDX) begin
         load_monitor_enable <= hwdata_i[LDMON_POS];
      end
   end

   // Status tracks the divider, not sticky
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         load_present_status <= 1'b0;
         load_monitor_pulldown_o <= 1'b0;
      end else begin
         load_present_status <= load_monitor_enable && sense.load_high;
         load_monitor_pulldown_o <= load_monitor_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Thermistor scan and external temperature check

   always_ff @(posedge clock_i) begin
      if (sys_rst_i || scan_cnt == CW'(SCAN_PERIOD_CYC - 1)) begin
         scan_cnt <= '0;
      end else begin
         scan_cnt <= scan_cnt + 1'b1;
      end
   end

   // Sources are ORed so the scans never disturb each other
   assign scan_win = !ovr.auto_scan_disable && (scan_cnt < CW'(SCAN_ON_CYC));
   // Analog select and force keep the divider powered
   assign meas_on = ovr.thermistor_supply_force
                 || (analog_out_select == AO_EXT_TEMP) || scan_win;
   assign settled = (settle_cnt == CW'(SETTLE_CYC));

   // Settling time restarts each time the supply comes on
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || !meas_on) begin
         settle_cnt <= '0;
      end else if (!settled) begin
         settle_cnt <= settle_cnt + 1'b1;
      end
   end

   // External hot holds until a settled reading shows recovery
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ext_hot <= 1'b0;
      end else if (settled) begin
         ext_hot <= sense.thermistor_low;
      end
   end

   // Overcurrent flags double as the host wake line
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         thermistor_supply_out_o <= 1'b0;
      end else begin
         thermistor_supply_out_o <= meas_on || flags.discharge_overcurrent_flag
                                 || flags.charge_overcurrent_flag
                                 || flags.short_circuit_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   trip_drives_off_a : assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      (doc_evt && !ovr.discharge_oc_override)
         |=> !charge_switch_drive_o && !discharge_switch_drive_o
             && !charge_switch_ctrl && !discharge_switch_ctrl)
      else $error("switch drive left on after overcurrent trip");

   doc_flag_set_a : assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      doc_evt |=> flags.discharge_overcurrent_flag)
      else $error("discharge overcurrent flag not set");

   sc_flag_trip_a : assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      (sc_evt && !ovr.short_circuit_override)
         |=> flags.short_circuit_flag && !discharge_switch_ctrl)
      else $error("short circuit did not trip");

   coc_flag_trip_a : assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      (coc_evt && !ovr.charge_oc_override)
         |=> flags.charge_overcurrent_flag && !charge_switch_ctrl)
      else $error("charge overcurrent did not trip");

   override_keeps_a : assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      (doc_evt && ovr.discharge_oc_override && !sc_evt && !coc_evt && !ot_hold
         && !(wr_en && dp_idx == CONTROL_IDX))
         |=> $stable(charge_switch_ctrl) && $stable(discharge_switch_ctrl))
      else $error("overridden fault changed switch control");

   wake_line_a : assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      (flags.short_circuit_flag || flags.charge_overcurrent_flag
         || flags.discharge_overcurrent_flag)
         |=> thermistor_supply_out_o)
      else $error("wake line low with overcurrent flag set");

   load_status_off_a : assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      !load_monitor_enable ##1 !load_monitor_enable |-> !load_present_status)
      else $error("load status set with monitor off");

   scan_window_end_a : assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      (scan_cnt == CW'(SCAN_ON_CYC) && !ovr.thermistor_supply_force
         && analog_out_select != AO_EXT_TEMP && flags[2:0] == 3'h0
         && !flag_set.discharge_overcurrent_flag && !flag_set.charge_overcurrent_flag
         && !flag_set.short_circuit_flag)
         |=> !thermistor_supply_out_o)
      else $error("thermistor supply stayed on past scan window");

   settle_before_check_a : assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      (!meas_on ##1 meas_on) |-> !settled)
      else $error("temperature compared before settling");

   force_supply_a : assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      ovr.thermistor_supply_force |=> thermistor_supply_out_o)
      else $error("force bit did not power thermistor");

   hot_lockout_a : assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      ot_hold |=> !charge_switch_ctrl && !discharge_switch_ctrl && balance == BAL_RST)
      else $error("switch or balance accepted during shutdown");

   flag_sticky_a : assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      (flags.discharge_overcurrent_flag && !flag_clr.discharge_overcurrent_flag)
         |=> flags.discharge_overcurrent_flag)
      else $error("fault flag dropped without clear");

endmodule

// >>> tb/ppc_host_model.sv
// Host controller model: an AHB-Lite master for register access.
// Assumes one slave whose hreadyout is fed back as hready_i.
`timescale 1ns/100ps
module ppc_host_model (
   input wire logic clock_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_i,
   output logic [1:0] htrans_o = 2'h0,
   output logic [31:0] haddr_o = 32'h0000_0000,
   output logic hwrite_o = 1'b0,
   output logic [31:0] hwdata_o = 32'h0000_0000
);
   ////////////////////////////////////////////////////////////
   // One word transfer; call just after a rising edge, waits on hready only
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
         output logic [31:0] q);
      htrans_o <= 2'h2;
      haddr_o <= a;
      hwrite_o <= wr;
      @(posedge clock_i);
      while (hready_i !== 1'b1) @(posedge clock_i);
      htrans_o <= 2'h0;
      hwdata_o <= d;
      @(posedge clock_i);
      while (hready_i !== 1'b1) @(posedge clock_i);
      q = hrdata_i;
   endtask
endmodule

// >>> tb/tb_top.sv
// Testbench for the pack protection controller, driving faults and registers.
// Assumes the short timing parameters below; host model issues bus cycles.
`timescale 1ns/100ps
module tb_top;
   import ppc_pkg::*;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   ppc_sense_s sense_i = '0;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata;
   logic hwrite, hready, chg, dis, pull, therm;
   logic [5:0] bal;
   logic resp;
   logic [3:0] aosel;
   logic [7:0] dcfg, ccfg;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   initial forever #10 clock_i = ~clock_i;
   ppc_host_model u_host (.clock_i(clock_i), .hready_i(hready), .hrdata_i(hrdata),
      .htrans_o(htrans), .haddr_o(haddr), .hwrite_o(hwrite), .hwdata_o(hwdata));
   ppc_top #(.OC_UNIT_CYC(8), .SC_UNIT_CYC(4), .SCAN_PERIOD_CYC(200), .SCAN_ON_CYC(40),
      .SETTLE_CYC(10)) i_ppc_top (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(1'b1),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(resp), .sense_i(sense_i), .charge_switch_drive_o(chg),
      .discharge_switch_drive_o(dis), .balance_o(bal), .load_monitor_pulldown_o(pull),
      .thermistor_supply_out_o(therm), .analog_out_select_o(aosel), .discharge_cfg_o(dcfg),
      .charge_cfg_o(ccfg));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      u_host.xfer(1'b1, {27'h000_0000, a}, d, q);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      u_host.xfer(1'b0, {27'h000_0000, a}, 32'h0000_0000, q);
      chk("register", e, q);
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   // Each overcurrent fault source, automatic then overridden; scan off so supply means wake
   task automatic test_oc();
      int sb, fb, ob, ov;
      wr(5'h14, 32'h0000_0030);
      wr(5'h18, 32'h0000_0004);
      rd(5'h18, 32'h0000_0004);
      chk("discharge cfg", 32'h0000_0030, dcfg);
      chk("charge cfg", 32'h0000_0004, ccfg);
      chk("response", 0, resp);
      for (int k = 0; k < 6; k++) begin
         sb = 5 - k % 3;
         fb = k % 3;
         ob = (fb == 0) ? 0 : 3 - fb;
         ov = k / 3;
         wr(5'h0C, 32'h0000_0020 | (ov << ob));
         wr(5'h04, 32'h0000_0003);
         chk("supply idle", 0, therm);
         sense_i[sb] <= 1'b1;
         wait_cyc(20);
         if (k == 0) chk("delay not expired", 1, dis);
         wait_cyc(40);
         chk("discharge drive", ov, dis);
         chk("charge drive", ov, chg);
         rd(5'h04, ov ? 3 : 0);
         chk("wake supply", 1, therm);
         sense_i[sb] <= 1'b0;
         wait_cyc(5);
         rd(5'h00, 1 << fb);
         wr(5'h00, 1 << fb);
         rd(5'h00, 0);
      end
   endtask
   // Internal heat shuts down and locks writes, then its override
   task automatic test_ot();
      wr(5'h0C, 32'h0000_0020);
      wr(5'h04, 32'h0000_0003);
      wr(5'h08, 32'h0000_003F);
      sense_i.internal_hot <= 1'b1;
      wait_cyc(10);
      chk("balance", 0, bal);
      chk("drive", 0, dis);
      wr(5'h04, 32'h0000_0003);
      wr(5'h08, 32'h0000_003F);
      rd(5'h04, 0);
      rd(5'h08, 0);
      wr(5'h0C, 32'h0000_0028);
      wr(5'h04, 32'h0000_0003);
      wait_cyc(10);
      chk("overridden drive", 1, dis);
      rd(5'h00, 8);
      sense_i.internal_hot <= 1'b0;
      wait_cyc(5);
      wr(5'h00, 32'h0000_001F);
   endtask
   task automatic test_load();
      chk("pulldown default", 0, pull);
      wr(5'h04, 32'h0000_0004);
      sense_i.load_high <= 1'b1;
      wait_cyc(5);
      chk("pulldown", 1, pull);
      rd(5'h00, 32'h0000_0020);
      sense_i.load_high <= 1'b0;
      wait_cyc(5);
      rd(5'h00, 0);
   endtask
   // Supply-on cycles in a 200-cycle period for one scan setting
   task automatic scan(input logic [31:0] ov, input logic [31:0] ao, input int e);
      int n;
      n = 0;
      wr(5'h0C, ov);
      wr(5'h10, ao);
      wait_cyc(20);
      chk("select out", ao, aosel);
      repeat (200) begin
         @(posedge clock_i);
         n += (therm === 1'b1);
      end
      chk("supply on count", e, n);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Cut a hang short; the run needs well under 6000 cycles
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      wait_cyc(12);
      sys_rst_i <= 1'b0;
      @(posedge clock_i);
      rd(5'h1C, 0);
      test_oc();
      $display("overcurrent test done");
      test_ot();
      $display("overtemp test done");
      test_load();
      $display("load test done");
      scan(0, 0, 40);
      scan(32'h0000_0020, 9, 200);
      scan(32'h0000_0020, 0, 0);
      scan(32'h0000_0060, 0, 200);
      sense_i.thermistor_low <= 1'b1;
      scan(0, 0, 40);
      rd(5'h00, 32'h0000_0010);
      // External heat: override lets the host drive, removing it shuts down
      wr(5'h0C, 32'h0000_0050);
      wr(5'h04, 32'h0000_0003);
      wait_cyc(5);
      chk("external override drive", 1, dis);
      wr(5'h0C, 32'h0000_0040);
      wait_cyc(5);
      chk("external hot drive", 0, dis);
      rd(5'h04, 0);
      $display("scan test done");
      finish_test();
   end
endmodule
